/* File: hdl/rbps_sequencer.sv */
/*
  Reset, brownout and PLL start-up sequencer with AXI4-Lite registers.
  Assumes pins and analog flags are asynchronous to aclk; aclk stands in for the VCO.
*/
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
// Notes on behaviour
// - Reset pin is active low: low requests reset, high releases it.
// - Core leaves reset only after PLL lock is seen, even with pin high.
// - Boot select pin is latched at pin rise: high normal, low bootstrap.
// - Transmit pin low during reset with boot select low enters test mode.
// - On reset exit the boot select pin becomes an output.
// - Execution starts at code address zero after reset.
// - After internal reset, port 1 and 3 latches load ones, ports are inputs.
// - Reset never clears internal or extended RAM.
// - Pin low puts device in reset with all ports input or high impedance.
// - Internal reset releases only after 4096 continuous locked cycles.
// - Enabled brownout lasting the detection interval resets the device.
// - After brownout recovery, reset releases after 4096 locked clocks.
// - Brownout flag bit 3 set by hardware, cleared by pin reset or software.
// - Enable bit 4: zero ignores brownout, one resets and sets flag.
// - All ports are high impedance while brownout lasts.
// - Control register bits 7 to 5 read zero; software writes zeros.
// - Lock loss resets device and sets loss flag, cleared by pin or software.
// - Feedback divider fixed at fifteen.
// - Software power-down powers down the PLL.
// - Output clock is VCO divided by selected factor; reset code is 4.
// - Divider changes switch glitch-free, no shortened pulses.
// - Codes 0..7 give factors 2,16,4,5,6,8,9,10.
`timescale 1ns/1ps
module rbps_sequencer
  import rbps_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic reset_pin_n,
  input wire logic brownout_det,
  input wire logic pll_lock,
  input wire logic boot_mode_select_pin_i,
  input wire logic txd_pin_i,
  input wire logic powerdown_req,
  output logic internal_reset_n,
  output logic normal_mode,
  output logic test_mode,
  output logic boot_mode_select_pin_o,
  output logic boot_mode_select_pin_oe_n,
  output logic ports_hiz,
  output logic ports_input,
  output logic [7:0] port1_latch,
  output logic [7:0] port3_latch,
  output logic [15:0] code_start_addr,
  output logic [3:0] pll_feedback_div,
  output logic pll_powerdown,
  output logic pll_clk
);

  typedef struct packed {
    logic rst_m;
    logic rst_s;
    logic bo_m;
    logic bo_s;
    logic lk_m;
    logic lk_s;
    logic bsl_m;
    logic bsl_s;
    logic txd_m;
    logic txd_s;
    rbps_state_t state;
    logic [12:0] lock_cnt;
    logic [7:0] bo_cnt;
    logic txd_low_seen;
    logic normal_mode;
    logic test_mode;
    logic brownout_enable;
    logic bo_flag;
    logic ws;
    logic ewpd;
    logic pll_flag;
    logic [2:0] kdiv;
    logic [4:0] rel;
    logic [4:0] k_active;
    logic [4:0] div_cnt;
    logic pll_clk;
    logic int_rst_n;
    logic ports_hiz;
    logic ports_input;
    logic [7:0] p1;
    logic [7:0] p3;
    logic bsl_oe_n;
    logic pll_pd;
    logic aw_have;
    logic [7:0] awaddr;
    logic w_have;
    logic [7:0] wdata;
    logic wstrb0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rbps_regs_t;

  rbps_regs_t st_reg;
  rbps_regs_t st_next;
  logic bo_persist;
  logic [7:0] wbc_view;

  // ==========================================================
  // Next-state logic
  always_comb begin
    st_next = st_reg;
    bo_persist = 1'b0;
    wbc_view = 8'h00;

    // Two-stage synchronisers
    st_next.rst_m = reset_pin_n;
    st_next.rst_s = st_reg.rst_m;
    st_next.bo_m = brownout_det;
    st_next.bo_s = st_reg.bo_m;
    st_next.lk_m = pll_lock;
    st_next.lk_s = st_reg.lk_m;
    st_next.bsl_m = boot_mode_select_pin_i;
    st_next.bsl_s = st_reg.bsl_m;
    st_next.txd_m = txd_pin_i;
    st_next.txd_s = st_reg.txd_m;

    // Brownout filter counts only while the pin is high
    if (st_reg.bo_s && st_reg.rst_s) begin
      if (st_reg.bo_cnt != 8'(BO_DETECT_CYCLES - 1)) begin
        st_next.bo_cnt = st_reg.bo_cnt + 8'h01;
      end
    end else begin
      st_next.bo_cnt = 8'h00;
    end
    bo_persist = st_reg.bo_s && st_reg.rst_s && (st_reg.bo_cnt == 8'(BO_DETECT_CYCLES - 1));

    // ========================================================
    // Sequencer
    unique case (st_reg.state)
      RBPS_HOLD: begin
        if (!st_reg.txd_s) begin
          st_next.txd_low_seen = 1'b1;
        end
        if (st_reg.rst_s) begin
          st_next.normal_mode = st_reg.bsl_s;
          st_next.test_mode = !st_reg.bsl_s && (st_reg.txd_low_seen || !st_reg.txd_s);
          st_next.txd_low_seen = 1'b0;
          st_next.lock_cnt = 13'h0000;
          st_next.state = RBPS_LOCKWAIT;
        end
      end
      RBPS_LOCKWAIT: begin
        if (!st_reg.lk_s) begin
          st_next.lock_cnt = 13'h0000;
        end else if (st_reg.lock_cnt == 13'(LOCK_CYCLES - 1)) begin
          st_next.state = RBPS_RUN;
        end else begin
          st_next.lock_cnt = st_reg.lock_cnt + 13'h0001;
        end
      end
      RBPS_RUN: begin
        if (bo_persist && st_reg.brownout_enable) begin
          st_next.state = RBPS_BROWNOUT;
        end else if (!st_reg.lk_s && !st_reg.pll_pd) begin
          st_next.state = RBPS_LOCKWAIT;
          st_next.lock_cnt = 13'h0000;
        end
      end
      RBPS_BROWNOUT: begin
        if (!st_reg.bo_s) begin
          st_next.state = RBPS_LOCKWAIT;
          st_next.lock_cnt = 13'h0000;
        end
      end
    endcase
    // Pin low overrides every state
    if (!st_reg.rst_s) begin
      st_next.state = RBPS_HOLD;
    end

    // Internal reset and port control follow the next state
    st_next.int_rst_n = (st_next.state == RBPS_RUN);
    st_next.ports_hiz = (st_next.state != RBPS_RUN) || st_reg.bo_s;
    st_next.bsl_oe_n = (st_next.state != RBPS_RUN);
    if (st_next.state != RBPS_RUN) begin
      st_next.ports_input = 1'b1;
      st_next.p1 = PORT_LATCH_RESET;
      st_next.p3 = PORT_LATCH_RESET;
    end
    st_next.pll_pd = powerdown_req && st_reg.int_rst_n;

    // ========================================================
    // AXI4-Lite slave
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.aw_have = 1'b1;
      st_next.awaddr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.w_have = 1'b1;
      st_next.wdata = s_axi_wdata[7:0];
      st_next.wstrb0 = s_axi_wstrb[0];
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid) begin
      st_next.aw_have = 1'b0;
      st_next.w_have = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = RESP_OKAY;
      unique case (st_reg.awaddr)
        WBC_OFFSET: begin
          if (st_reg.wstrb0) begin
            st_next.ewpd = st_reg.wdata[WBC_EWPD_BIT];
            st_next.ws = st_reg.wdata[WBC_WS_BIT];
            st_next.bo_flag = st_reg.wdata[WBC_BO_BIT];
            st_next.brownout_enable = st_reg.wdata[WBC_EBO_BIT];
          end
        end
        CCR_OFFSET: begin
          if (st_reg.wstrb0) begin
            st_next.rel = st_reg.wdata[CCR_REL_LSB +: 5];
            st_next.kdiv = st_reg.wdata[CCR_KDIV_LSB +: 3];
          end
        end
        SCW_OFFSET: begin
          if (st_reg.wstrb0) begin
            st_next.pll_flag = st_reg.wdata[SCW_PLL_LOSS_RESET_FLAG_BIT];
          end
        end
        STAT_OFFSET: begin
        end
        default: begin
          st_next.bresp = RESP_SLVERR;
        end
      endcase
    end
    // Hardware set wins over a software clear in the same cycle
    if (st_reg.state == RBPS_RUN && bo_persist && st_reg.brownout_enable) begin
      st_next.bo_flag = 1'b1;
    end
    if (st_reg.state == RBPS_RUN && !st_reg.lk_s && !st_reg.pll_pd) begin
      st_next.pll_flag = 1'b1;
    end
    // Pin reset clears both flags and reloads all control bits with their reset values
    if (!st_reg.rst_s) begin
      st_next.bo_flag = 1'b0;
      st_next.pll_flag = 1'b0;
      st_next.brownout_enable = WBC_RESET[WBC_EBO_BIT];
      st_next.ws = WBC_RESET[WBC_WS_BIT];
      st_next.ewpd = WBC_RESET[WBC_EWPD_BIT];
      st_next.kdiv = CCR_RESET[CCR_KDIV_LSB +: 3];
      st_next.rel = CCR_RESET[CCR_REL_LSB +: 5];
    end
    st_next.awready = !st_next.aw_have && !st_next.bvalid;
    st_next.wready = !st_next.w_have && !st_next.bvalid;

    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    wbc_view[WBC_EWPD_BIT] = st_reg.ewpd;
    wbc_view[WBC_WS_BIT] = st_reg.ws;
    wbc_view[WBC_BO_BIT] = st_reg.bo_flag;
    wbc_view[WBC_EBO_BIT] = st_reg.brownout_enable;
    if (s_axi_arvalid && st_reg.arready) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = RESP_OKAY;
      st_next.rdata = 32'h0000_0000;
      unique case (s_axi_araddr[7:0])
        WBC_OFFSET: st_next.rdata[7:0] = wbc_view;
        CCR_OFFSET: st_next.rdata[7:0] = {st_reg.kdiv, st_reg.rel};
        SCW_OFFSET: st_next.rdata[SCW_PLL_LOSS_RESET_FLAG_BIT] = st_reg.pll_flag;
        STAT_OFFSET: begin
          st_next.rdata[STAT_INTRST_BIT] = !st_reg.int_rst_n;
          st_next.rdata[STAT_NORMAL_BIT] = st_reg.normal_mode;
          st_next.rdata[STAT_TEST_BIT] = st_reg.test_mode;
          st_next.rdata[STAT_LOCK_BIT] = st_reg.lk_s;
          st_next.rdata[STAT_BROWN_BIT] = st_reg.bo_s;
        end
        default: st_next.rresp = RESP_SLVERR;
      endcase
    end
    st_next.arready = !st_next.rvalid;

    // ========================================================
    // Output divider; new factor taken only at period end
    if (st_reg.pll_pd) begin
      st_next.div_cnt = 5'h00;
      st_next.pll_clk = 1'b0;
    end else begin
      if (st_reg.div_cnt >= st_reg.k_active - 5'h01) begin
        st_next.div_cnt = 5'h00;
        st_next.k_active = rbps_kfactor(st_reg.kdiv);
      end else begin
        st_next.div_cnt = st_reg.div_cnt + 5'h01;
      end
      st_next.pll_clk = st_next.div_cnt < (st_next.k_active >> 1);
    end
  end

  // ==========================================================
  // State register; RAM is outside and never touched here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.state <= RBPS_HOLD;
      st_reg.ports_hiz <= 1'b1;
      st_reg.ports_input <= 1'b1;
      st_reg.p1 <= PORT_LATCH_RESET;
      st_reg.p3 <= PORT_LATCH_RESET;
      st_reg.bsl_oe_n <= 1'b1;
      st_reg.kdiv <= CCR_RESET[CCR_KDIV_LSB +: 3];
      st_reg.rel <= CCR_RESET[CCR_REL_LSB +: 5];
      st_reg.k_active <= rbps_kfactor(CCR_RESET[CCR_KDIV_LSB +: 3]);
      st_reg.normal_mode <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Outputs
  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign internal_reset_n = st_reg.int_rst_n;
  assign normal_mode = st_reg.normal_mode;
  assign test_mode = st_reg.test_mode;
  assign boot_mode_select_pin_o = st_reg.int_rst_n;
  assign boot_mode_select_pin_oe_n = st_reg.bsl_oe_n;
  assign ports_hiz = st_reg.ports_hiz;
  assign ports_input = st_reg.ports_input;
  assign port1_latch = st_reg.p1;
  assign port3_latch = st_reg.p3;
  assign code_start_addr = RESET_VECTOR;
  assign pll_feedback_div = FEEDBACK_DIV;
  assign pll_powerdown = st_reg.pll_pd;
  assign pll_clk = st_reg.pll_clk;

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  pin_low_hold_a: assert property (!st_reg.rst_s |=> st_reg.state == RBPS_HOLD)
    else $error("pin low did not hold reset");
  lock_before_run_a: assert property
    (st_reg.state == RBPS_LOCKWAIT && st_next.state == RBPS_RUN
      |-> st_reg.lock_cnt == 13'(LOCK_CYCLES - 1) && st_reg.lk_s)
    else $error("released before full lock count");
  lock_drop_restart_a: assert property
    (st_reg.state == RBPS_LOCKWAIT && !st_reg.lk_s && st_reg.rst_s
      |=> st_reg.lock_cnt == 13'h0000 && !internal_reset_n)
    else $error("lock count not restarted");
  run_means_release_a: assert property
    (st_reg.state == RBPS_RUN |=> internal_reset_n || st_reg.state != RBPS_RUN)
    else $error("internal reset stuck in run");
  boot_latch_a: assert property
    (st_reg.state == RBPS_HOLD && st_reg.rst_s |=> normal_mode == $past(st_reg.bsl_s))
    else $error("boot mode not latched at release");
  brownout_reset_a: assert property
    (st_reg.state == RBPS_RUN && bo_persist && st_reg.brownout_enable && st_reg.rst_s
      |=> st_reg.bo_flag ##1 !internal_reset_n)
    else $error("enabled brownout did not reset");
  brownout_ignored_a: assert property
    (st_reg.state == RBPS_RUN && !st_reg.brownout_enable && st_reg.lk_s && st_reg.rst_s
      |=> st_reg.state == RBPS_RUN)
    else $error("disabled brownout caused reset");
  hiz_brownout_a: assert property (st_reg.bo_s |=> ports_hiz)
    else $error("ports driven during brownout");
  pll_loss_a: assert property
    (st_reg.state == RBPS_RUN && !st_reg.lk_s && !st_reg.pll_pd && st_reg.rst_s
      && !(bo_persist && st_reg.brownout_enable) |=> st_reg.pll_flag && st_reg.state == RBPS_LOCKWAIT)
    else $error("lock loss not flagged");
  div_change_a: assert property
    ($changed(st_reg.k_active) |-> st_reg.div_cnt == 5'h00 && pll_clk)
    else $error("divider switched mid period");
  bsl_output_a: assert property ($rose(internal_reset_n) |-> !boot_mode_select_pin_oe_n)
    else $error("boot select not driven after reset");

  run_reached_c: cover property (st_reg.state == RBPS_LOCKWAIT ##1 st_reg.state == RBPS_RUN);
  brownout_c: cover property (st_reg.state == RBPS_BROWNOUT);
  test_mode_c: cover property ($rose(test_mode));

endmodule : rbps_sequencer

/* File: hdl/rbps_pkg.sv */
/*
  Constants, register map and types for the reset, brownout and PLL sequencer.
  Assumes a 100 MHz aclk and a 32-bit AXI4-Lite register bus.
*/
package rbps_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int LOCK_CYCLES = 4096;
  localparam int BO_DETECT_NS = 1000;
  localparam int BO_DETECT_CYCLES = (BO_DETECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] WBC_OFFSET = 8'h00;
  localparam logic [7:0] CCR_OFFSET = 8'h04;
  localparam logic [7:0] SCW_OFFSET = 8'h08;
  localparam logic [7:0] STAT_OFFSET = 8'h0C;

  // ==========================================================
  // Field positions
  localparam int WBC_EWPD_BIT = 0;
  localparam int WBC_WS_BIT = 1;
  localparam int WBC_EBO_BIT = 4;
  localparam int WBC_BO_BIT = 3;
  localparam int CCR_REL_LSB = 0;
  localparam int CCR_KDIV_LSB = 5;
  localparam int SCW_PLL_LOSS_RESET_FLAG_BIT = 0;
  localparam int STAT_INTRST_BIT = 0;
  localparam int STAT_NORMAL_BIT = 1;
  localparam int STAT_TEST_BIT = 2;
  localparam int STAT_LOCK_BIT = 3;
  localparam int STAT_BROWN_BIT = 4;

  // ==========================================================
  // Reset values and fixed figures
  localparam logic [7:0] WBC_RESET = 8'h00;
  localparam logic [7:0] CCR_RESET = 8'h9F;
  localparam logic [7:0] PORT_LATCH_RESET = 8'hFF;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [3:0] FEEDBACK_DIV = 4'hF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RBPS_HOLD,
    RBPS_LOCKWAIT,
    RBPS_RUN,
    RBPS_BROWNOUT
  } rbps_state_t;

  // Output divider code to factor K
  function automatic logic [4:0] rbps_kfactor(input logic [2:0] code);
    logic [4:0] k;
    k = 5'h02;
    unique case (code)
      3'h0: k = 5'h02;
      3'h1: k = 5'h10;
      3'h2: k = 5'h04;
      3'h3: k = 5'h05;
      3'h4: k = 5'h06;
      3'h5: k = 5'h08;
      3'h6: k = 5'h09;
      3'h7: k = 5'h0A;
    endcase
    return k;
  endfunction : rbps_kfactor

endpackage : rbps_pkg

/* File: verif/rbps_far_side.sv */
/*
  Far-side model: external reset network, oscillator lock, brownout and boot straps.
  Assumes the bench sets the command inputs just after a rising aclk edge.
*/
`timescale 1ns/1ps
module rbps_far_side (
  input wire logic aclk,
  input wire logic pin_low,
  input wire logic lock_ok,
  input wire logic brown,
  input wire logic strap,
  input wire logic txd_low,
  input wire logic boot_o,
  input wire logic boot_oe_n,
  output logic reset_pin_n,
  output logic pll_lock,
  output logic brownout_det,
  output logic boot_pin,
  output logic txd_pin
);
  // ==========================================================
  // Pins
  initial {reset_pin_n, pll_lock, brownout_det, txd_pin} = 4'h1;
  always @(posedge aclk) begin
    reset_pin_n <= ~pin_low;
    pll_lock <= lock_ok;
    brownout_det <= brown;
    txd_pin <= ~txd_low;
  end
  // Pull resistor holds the strap once the device lets go of the pin
  assign boot_pin = boot_oe_n ? strap : boot_o;
endmodule : rbps_far_side

/* File: verif/tb_top.sv */
/*
  Self-checking bench for the reset, brownout and PLL sequencer.
  Assumes the far-side model is compiled first and aclk stands for the VCO.
*/
`timescale 1ns/1ps
module tb_top;
  import rbps_pkg::*;
  // ==========================================================
  // Signals
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, wd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic s_axi_bready = 1, s_axi_rready = 1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic reset_pin_n, brownout_det, pll_lock, boot_mode_select_pin_i, txd_pin_i;
  logic powerdown_req = 0;
  logic internal_reset_n, normal_mode, test_mode, boot_mode_select_pin_o;
  logic boot_mode_select_pin_oe_n, ports_hiz, ports_input, pll_powerdown, pll_clk;
  logic [7:0] port1_latch, port3_latch;
  logic [15:0] code_start_addr;
  logic [3:0] pll_feedback_div;
  logic pin_low = 1, lock_ok = 0, brown = 0, strap = 1, txd_low = 0;
  logic [7:0] rnd = 8'h43;
  int n_fail = 0, comparisons = 0, kold = 6;
  int kt[8] = '{2, 16, 4, 5, 6, 8, 9, 10};
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  realtime t0, t1, t2, t3;

  always #5 aclk = ~aclk;

  rbps_sequencer i_dut (.*);
  rbps_far_side i_far (.aclk(aclk), .pin_low(pin_low), .lock_ok(lock_ok), .brown(brown),
    .strap(strap), .txd_low(txd_low), .boot_o(boot_mode_select_pin_o),
    .boot_oe_n(boot_mode_select_pin_oe_n), .reset_pin_n(reset_pin_n), .pll_lock(pll_lock),
    .brownout_det(brownout_det), .boot_pin(boot_mode_select_pin_i), .txd_pin(txd_pin_i));

  // ==========================================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr

  // Ready lines drop after each accepted beat until bvalid clears, so no same-step re-raise
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic pa, pw;
    pa = 1;
    pw = 1;
    bq.push_back(er);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (pa || pw) begin
      @(posedge aclk);
      if (pa && s_axi_awready === 1'b1) begin
        pa = 0;
        s_axi_awvalid <= 0;
      end
      if (pw && s_axi_wready === 1'b1) begin
        pw = 0;
        s_axi_wvalid <= 0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    rq.push_back({er, ed});
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
  endtask : axr

  // Cycles from the call until internal reset lifts
  task automatic wait_run(input int lo, input int hi);
    int n;
    n = 0;
    while (internal_reset_n !== 1'b1 && n <= hi) begin
      @(posedge aclk);
      n++;
    end
    chk("lock_count", n >= lo && n <= hi, 1);
  endtask : wait_run

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // Response monitor
  always @(posedge aclk) begin
    logic [33:0] e;
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1 && bq.size() > 0)
      chk("bresp", {30'h0, s_axi_bresp}, {30'h0, bq.pop_front()});
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1 && rq.size() > 0) begin
      e = rq.pop_front();
      chk("rdata", s_axi_rdata, e[31:0]);
      chk("rresp", {30'h0, s_axi_rresp}, {30'h0, e[33:32]});
    end
  end

  initial begin
    repeat (40000) @(posedge aclk);
    n_fail++;
    tally_and_finish();
  end

  // ==========================================================
  // Scenarios
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    axr(WBC_OFFSET, 32'h00, RESP_OKAY);
    axr(CCR_OFFSET, 32'h9F, RESP_OKAY);
    axr(8'h10, 32'h0, RESP_SLVERR);
    axw(8'h10, 32'hFF, RESP_SLVERR);
    pin_low <= 0;
    repeat (50) @(posedge aclk);
    chk("held", {internal_reset_n, ports_hiz, port1_latch}, 10'h1FF);
    lock_ok <= 1;
    repeat (2000) @(posedge aclk);
    lock_ok <= 0;
    repeat (5) @(posedge aclk);
    lock_ok <= 1;
    wait_run(4098, 4106);
    chk("run_pins", {normal_mode, test_mode, boot_mode_select_pin_oe_n, ports_input}, 4'h9);
    chk("latches", {port1_latch, port3_latch, code_start_addr}, 32'hFFFF0000);
    chk("fb_div", pll_feedback_div, 4'hF);
    axw(STAT_OFFSET, 32'hFF, RESP_OKAY);
    axr(STAT_OFFSET, 32'h0A, RESP_OKAY);
    $display("test power_on done");
    axw(WBC_OFFSET, 32'hF0, RESP_OKAY);
    axr(WBC_OFFSET, 32'h10, RESP_OKAY);
    for (int c = 0; c < 8; c++) begin
      rnd = lfsr(rnd);
      wd = {24'h0, 3'(c), rnd[4:0]};
      axw(CCR_OFFSET, wd, RESP_OKAY);
      @(posedge pll_clk) t0 = $realtime;
      @(posedge pll_clk) t1 = $realtime;
      @(negedge pll_clk) t2 = $realtime;
      @(posedge pll_clk) t3 = $realtime;
      chk("k_first", int'((t1 - t0) / 10) inside {kt[c], kold}, 1);
      chk("k_period", int'((t3 - t1) / 10), kt[c]);
      chk("k_high", int'((t2 - t1) / 10), kt[c] / 2);
      kold = kt[c];
      @(posedge aclk);
      axr(CCR_OFFSET, wd, RESP_OKAY);
    end
    $display("test divider done");
    brown <= 1;
    repeat (95) @(posedge aclk);
    chk("bo_early", {internal_reset_n, ports_hiz}, 2'h3);
    repeat (20) @(posedge aclk);
    chk("bo_reset", {internal_reset_n, ports_hiz}, 2'h1);
    axr(WBC_OFFSET, 32'h18, RESP_OKAY);
    brown <= 0;
    wait_run(4098, 4112);
    axw(WBC_OFFSET, 32'h10, RESP_OKAY);
    axr(WBC_OFFSET, 32'h10, RESP_OKAY);
    axw(WBC_OFFSET, 32'h00, RESP_OKAY);
    brown <= 1;
    repeat (150) @(posedge aclk);
    chk("bo_off", internal_reset_n, 1);
    brown <= 0;
    axr(WBC_OFFSET, 32'h00, RESP_OKAY);
    $display("test brownout done");
    lock_ok <= 0;
    repeat (8) @(posedge aclk);
    chk("loss_reset", internal_reset_n, 0);
    axr(SCW_OFFSET, 32'h01, RESP_OKAY);
    lock_ok <= 1;
    wait_run(4098, 4106);
    axw(SCW_OFFSET, 32'h00, RESP_OKAY);
    axr(SCW_OFFSET, 32'h00, RESP_OKAY);
    powerdown_req <= 1;
    repeat (3) @(posedge aclk);
    chk("pd_on", pll_powerdown, 1);
    powerdown_req <= 0;
    repeat (3) @(posedge aclk);
    chk("pd_off", pll_powerdown, 0);
    $display("test lock_loss done");
    axw(CCR_OFFSET, 32'h1F, RESP_OKAY);
    strap <= 0;
    txd_low <= 1;
    pin_low <= 1;
    repeat (10) @(posedge aclk);
    chk("pin_reset", {internal_reset_n, ports_hiz, boot_mode_select_pin_oe_n}, 3'h3);
    axr(CCR_OFFSET, 32'h9F, RESP_OKAY);
    pin_low <= 0;
    wait_run(4098, 4112);
    txd_low <= 0;
    chk("test_mode", {test_mode, normal_mode, boot_mode_select_pin_i}, 3'h5);
    $display("test boot_modes done");
    tally_and_finish();
  end
endmodule : tb_top
